// File: core/opu_pkg.sv
// constants and register layout of the output protect unit
package opu_pkg;
    localparam int ADDR_W = 8;
    localparam int NUM_FAULT = 6;
    localparam int NUM_TPIN = 20;
    localparam int NUM_PPIN = 8;
    localparam int NUM_PAIR = 9;
    localparam int NUM_HIZEN = 22;
    localparam int NUM_STAT = 17;
    localparam int NUM_GRP = 5;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_INMODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ACTLVL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_HIZEN = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_INTEN = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_HALT = 8'h1C;
    // control register fields
    localparam int CTRL_FEN_LSB = 0;
    localparam int CTRL_SHORT1 = 6;
    localparam int CTRL_SHORT2 = 7;
    localparam int CTRL_GPIO = 8;
    localparam int CTRL_SW_LSB = 9;
    localparam int CTRL_W = 14;
    // status register fields
    localparam int ST_FAULT_LSB = 0;
    localparam int ST_SHORT_LSB = 6;
    localparam int ST_OSC = 15;
    localparam int ST_CMP = 16;
    // group index in software halt and halt status fields
    localparam int GRP_CH34 = 0;
    localparam int GRP_CH67 = 1;
    localparam int GRP_CH0 = 2;
    localparam int GRP_CH9 = 3;
    localparam int GRP_PWM = 4;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
    localparam logic [2*NUM_FAULT-1:0] INMODE_RST = 12'h000;
    localparam logic [2*NUM_PAIR-1:0] ACTLVL_RST = 18'h3FFFF;
    localparam logic [NUM_HIZEN-1:0] HIZEN_RST = 22'h000000;
    localparam logic [NUM_STAT-1:0] INTEN_RST = 17'h00000;
    // fault input detection modes
    typedef enum logic [1:0] {
        MODE_EDGE = 2'b00,
        MODE_DIV8 = 2'b01,
        MODE_DIV16 = 2'b10,
        MODE_DIV128 = 2'b11
    } in_mode_t;
    localparam int DIV_W = 7;
    localparam int LOW_SAMPLES = 16;
    localparam int SAMP_W = 5;
endpackage : opu_pkg

// File: core/output_protect_unit.sv
// output protect unit: fault detection and pin halt for timer and pwm outputs
`timescale 1ns/1ns
`default_nettype none
module output_protect_unit
    import opu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [opu_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [opu_pkg::NUM_FAULT-1:0] faultInN,
    input wire logic oscStop,
    input wire logic cmpDetect,
    input wire logic [opu_pkg::NUM_TPIN-1:0] timerPinLvl,
    input wire logic [opu_pkg::NUM_PPIN-1:0] pwmPinLvl,
    output logic [opu_pkg::NUM_TPIN-1:0] timerHiz,
    output logic [opu_pkg::NUM_TPIN-1:0] timerGpio,
    output logic [opu_pkg::NUM_PPIN-1:0] pwmHiz,
    output logic [opu_pkg::NUM_PPIN-1:0] pwmGpio,
    output logic irq
);
    import opu_pkg::*;

    logic [CTRL_W-1:0] ctrl_r;
    logic [2*NUM_FAULT-1:0] inMode_r;
    logic [2*NUM_PAIR-1:0] actLvl_r;
    logic [NUM_HIZEN-1:0] hizEn_r;
    logic [NUM_STAT-1:0] status_r;
    logic [NUM_STAT-1:0] status_nxt;
    logic [NUM_STAT-1:0] intEn_r;
    logic [31:0] rdData_r;
    logic [NUM_FAULT-1:0] faultPrev_r;
    logic [DIV_W-1:0] div_r;
    logic [SAMP_W-1:0] lowCnt_r [NUM_FAULT];
    logic [NUM_TPIN-1:0] timerHiz_r;
    logic [NUM_TPIN-1:0] timerGpio_r;
    logic [NUM_PPIN-1:0] pwmHiz_r;
    logic [NUM_PPIN-1:0] pwmGpio_r;

    // bus decode
    wire logic wrEn = psel & penable & pwrite;
    wire logic setup = psel & ~penable;
    wire logic hitCtrl = (paddr == OFS_CTRL);
    wire logic hitMode = (paddr == OFS_INMODE);
    wire logic hitLvl = (paddr == OFS_ACTLVL);
    wire logic hitHiz = (paddr == OFS_HIZEN);
    wire logic hitStat = (paddr == OFS_STATUS);
    wire logic hitClr = (paddr == OFS_CLEAR);
    wire logic hitIen = (paddr == OFS_INTEN);
    wire logic hitHalt = (paddr == OFS_HALT);
    wire logic hitAny = hitCtrl | hitMode | hitLvl | hitHiz | hitStat | hitClr | hitIen
        | hitHalt;
    wire logic [NUM_STAT-1:0] clrReq = (wrEn & hitClr) ? pwdata[NUM_STAT-1:0] : '0;

    // control fields
    wire logic [NUM_FAULT-1:0] faultEn = ctrl_r[CTRL_FEN_LSB +: NUM_FAULT];
    wire logic shortEn1 = ctrl_r[CTRL_SHORT1];
    wire logic shortEn2 = ctrl_r[CTRL_SHORT2];
    wire logic gpioMode = ctrl_r[CTRL_GPIO];
    wire logic [NUM_GRP-1:0] swHalt = ctrl_r[CTRL_SW_LSB +: NUM_GRP];

    // sampling clock enables from one free-running divider
    wire logic tick8 = (div_r[2:0] == 3'h7);
    wire logic tick16 = (div_r[3:0] == 4'hF);
    wire logic tick128 = (div_r == 7'h7F);

    // fault input detection
    logic [NUM_FAULT-1:0] faultDet;
    logic [NUM_FAULT-1:0] sampTick;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FAULT; gi++) begin : g_in
            wire in_mode_t mode = in_mode_t'(inMode_r[2*gi +: 2]);
            wire logic low = ~faultInN[gi];
            assign sampTick[gi] = (mode == MODE_DIV8) ? tick8 :
                                  (mode == MODE_DIV16) ? tick16 :
                                  (mode == MODE_DIV128) ? tick128 : 1'b0;
            // sixteenth consecutive low sample, or a falling edge
            assign faultDet[gi] = (mode == MODE_EDGE) ? (faultPrev_r[gi] & low) :
                (sampTick[gi] & low
                 & (lowCnt_r[gi] == SAMP_W'(LOW_SAMPLES - 1)));
            always_ff @(posedge clk) begin
                if (rst) begin
                    lowCnt_r[gi] <= '0;
                end else if (mode == MODE_EDGE || !low) begin
                    lowCnt_r[gi] <= '0;
                end else if (sampTick[gi] && lowCnt_r[gi] != SAMP_W'(LOW_SAMPLES)) begin
                    lowCnt_r[gi] <= lowCnt_r[gi] + SAMP_W'(1);
                end
            end
        end
    endgenerate

    // monitored pairs: first pin index, second pin index
    logic [NUM_PAIR-1:0] pairA;
    logic [NUM_PAIR-1:0] pairB;
    assign pairA[0] = timerPinLvl[4];
    assign pairB[0] = timerPinLvl[5];
    assign pairA[1] = timerPinLvl[6];
    assign pairB[1] = timerPinLvl[8];
    assign pairA[2] = timerPinLvl[7];
    assign pairB[2] = timerPinLvl[9];
    assign pairA[3] = timerPinLvl[10];
    assign pairB[3] = timerPinLvl[11];
    assign pairA[4] = timerPinLvl[12];
    assign pairB[4] = timerPinLvl[14];
    assign pairA[5] = timerPinLvl[13];
    assign pairB[5] = timerPinLvl[15];
    assign pairA[6] = pwmPinLvl[0];
    assign pairB[6] = pwmPinLvl[1];
    assign pairA[7] = pwmPinLvl[2];
    assign pairB[7] = pwmPinLvl[3];
    assign pairA[8] = pwmPinLvl[4];
    assign pairB[8] = pwmPinLvl[5];

    logic [NUM_PAIR-1:0] shortNow;
    generate
        for (gi = 0; gi < NUM_PAIR; gi++) begin : g_pair
            // both pins at their programmed active level
            assign shortNow[gi] = (pairA[gi] == actLvl_r[2*gi])
                & (pairB[gi] == actLvl_r[2*gi+1]);
        end
    endgenerate

    // sticky flags: set wins, clear only once the cause is gone
    wire logic [NUM_STAT-1:0] setEv = {cmpDetect, oscStop, shortNow, faultDet};
    wire logic [NUM_STAT-1:0] cond = {cmpDetect, oscStop, shortNow, ~faultInN};
    assign status_nxt = setEv | (status_r & ~(clrReq & ~cond));

    wire logic [NUM_FAULT-1:0] faultFlag = status_r[ST_FAULT_LSB +: NUM_FAULT];
    wire logic [NUM_PAIR-1:0] shortFlag = status_r[ST_SHORT_LSB +: NUM_PAIR];
    wire logic inFault = |(faultFlag & faultEn);
    wire logic allHalt = inFault | status_r[ST_OSC] | status_r[ST_CMP];
    wire logic timerShort = shortEn1 & (|shortFlag[5:0]);
    wire logic pwmShort = shortEn2 & (|shortFlag[8:6]);

    logic [NUM_GRP-1:0] grpHalt;
    assign grpHalt[GRP_CH34] = allHalt | timerShort | swHalt[GRP_CH34];
    assign grpHalt[GRP_CH67] = allHalt | timerShort | swHalt[GRP_CH67];
    assign grpHalt[GRP_CH0] = allHalt | swHalt[GRP_CH0];
    assign grpHalt[GRP_CH9] = allHalt | swHalt[GRP_CH9];
    assign grpHalt[GRP_PWM] = allHalt | pwmShort | swHalt[GRP_PWM];

    // per-pin enables: ch0 A-D, ch3 BD, ch4 AC, ch4 BD, ch6 BD, ch7 AC, ch7 BD,
    // ch9 A-D, pwm0-3 A/B
    logic [NUM_TPIN-1:0] tPinEn;
    logic [NUM_TPIN-1:0] tPinGrp;
    assign tPinEn = {hizEn_r[13:10],
                     hizEn_r[9], hizEn_r[8], hizEn_r[9], hizEn_r[8],
                     hizEn_r[7], hizEn_r[7],
                     hizEn_r[6], hizEn_r[5], hizEn_r[6], hizEn_r[5],
                     hizEn_r[4], hizEn_r[4],
                     hizEn_r[3:0]};
    assign tPinGrp = {{4{grpHalt[GRP_CH9]}}, {6{grpHalt[GRP_CH67]}},
                      {6{grpHalt[GRP_CH34]}}, {4{grpHalt[GRP_CH0]}}};
    wire logic [NUM_TPIN-1:0] tHalt = tPinEn & tPinGrp;
    wire logic [NUM_PPIN-1:0] pHalt = hizEn_r[21:14] & {NUM_PPIN{grpHalt[GRP_PWM]}};

    // read mux
    logic [31:0] rdMux;
    assign rdMux = hitCtrl ? {18'h00000, ctrl_r} :
                   hitMode ? {20'h00000, inMode_r} :
                   hitLvl ? {14'h0000, actLvl_r} :
                   hitHiz ? {10'h000, hizEn_r} :
                   hitStat ? {15'h0000, status_r} :
                   hitIen ? {15'h0000, intEn_r} :
                   hitHalt ? {27'h0000000, grpHalt} : 32'h00000000;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            inMode_r <= INMODE_RST;
            actLvl_r <= ACTLVL_RST;
            hizEn_r <= HIZEN_RST;
            intEn_r <= INTEN_RST;
        end else if (wrEn) begin
            if (hitCtrl) ctrl_r <= pwdata[CTRL_W-1:0];
            if (hitMode) inMode_r <= pwdata[2*NUM_FAULT-1:0];
            if (hitLvl) actLvl_r <= pwdata[2*NUM_PAIR-1:0];
            if (hitHiz) hizEn_r <= pwdata[NUM_HIZEN-1:0];
            if (hitIen) intEn_r <= pwdata[NUM_STAT-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_r <= '0;
            // idle level of the active-low inputs
            faultPrev_r <= '1;
            div_r <= '0;
            rdData_r <= 32'h00000000;
        end else begin
            status_r <= status_nxt;
            faultPrev_r <= faultInN;
            div_r <= div_r + DIV_W'(1);
            if (setup) rdData_r <= rdMux;
        end
    end

    // halted pins: high impedance or handed back to general I/O
    always_ff @(posedge clk) begin
        if (rst) begin
            timerHiz_r <= '0;
            timerGpio_r <= '0;
            pwmHiz_r <= '0;
            pwmGpio_r <= '0;
        end else begin
            timerHiz_r <= tHalt & {NUM_TPIN{~gpioMode}};
            timerGpio_r <= tHalt & {NUM_TPIN{gpioMode}};
            pwmHiz_r <= pHalt & {NUM_PPIN{~gpioMode}};
            pwmGpio_r <= pHalt & {NUM_PPIN{gpioMode}};
        end
    end

    assign timerHiz = timerHiz_r;
    assign timerGpio = timerGpio_r;
    assign pwmHiz = pwmHiz_r;
    assign pwmGpio = pwmGpio_r;
    assign irq = |(status_r & intEn_r);
    assign prdata = rdData_r;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hitAny;
endmodule : output_protect_unit
`default_nettype wire

// File: tb/output_protect_unit_sva.sv
// port assertions for the output protect unit
`timescale 1ns/1ns
`default_nettype none
module output_protect_unit_sva
    import opu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [opu_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic oscStop,
    input wire logic cmpDetect,
    input wire logic [opu_pkg::NUM_TPIN-1:0] timerHiz,
    input wire logic [opu_pkg::NUM_TPIN-1:0] timerGpio,
    input wire logic irq
);
    logic hz_r;
    logic oscIe_r;
    logic gpio_r;
    logic wrEn;
    logic wrCtrl;
    assign wrEn = psel && penable && pwrite && pready;
    assign wrCtrl = wrEn && (paddr == OFS_CTRL);
    always_ff @(posedge clk) begin
        if (rst) begin
            hz_r <= 1'b0;
            oscIe_r <= 1'b0;
            gpio_r <= 1'b0;
        end else begin
            if (wrEn && paddr == OFS_HIZEN) hz_r <= pwdata[0];
            if (wrEn && paddr == OFS_INTEN) oscIe_r <= pwdata[ST_OSC];
            if (wrCtrl) gpio_r <= pwdata[CTRL_GPIO];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_osc_irq: assert property (oscStop && oscIe_r |=> irq)
        else $error("osc stop gave no irq");
    a_cmp_halt: assert property (cmpDetect && hz_r |-> ##2 (timerHiz[0] || timerGpio[0]))
        else $error("comparator did not halt");
    a_sw_halt: assert property (wrCtrl && pwdata[11] && hz_r |-> ##2 (timerHiz[0] || timerGpio[0]))
        else $error("software halt missing");
    a_enable_gate: assert property (!$past(hz_r) |-> !(timerHiz[0] || timerGpio[0]))
        else $error("pin halted while disabled");
    a_halt_hold: assert property ($fell(timerHiz[0]) |-> $past(wrEn) || $past(wrEn, 2) || $past(rst))
        else $error("halt dropped without write");
    a_gpio_mode: assert property (|timerGpio |-> $past(gpio_r))
        else $error("gpio halt in high-z mode");
    a_hiz_mode: assert property (|timerHiz |-> !$past(gpio_r))
        else $error("high-z halt in gpio mode");
    a_irq_drop: assert property ($fell(irq) |-> $past(wrEn) || $past(rst))
        else $error("irq fell without write");
    a_unmapped_err: assert property (psel && penable && paddr > OFS_HALT |-> pslverr)
        else $error("unmapped access not refused");
    c_osc: cover property (oscStop && oscIe_r);
    c_gpio: cover property (|timerGpio);
    c_irq: cover property ($fell(irq));
endmodule // output_protect_unit_sva
bind output_protect_unit output_protect_unit_sva output_protect_unit_sva_inst (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .oscStop(oscStop), .cmpDetect(cmpDetect),
    .timerHiz(timerHiz), .timerGpio(timerGpio), .irq(irq));
`default_nettype wire

// File: tb/pin_model.sv
// far-side model of the monitored timer and pwm pins
`timescale 1ns/1ns
`default_nettype none
module pin_model
    import opu_pkg::*;
(
    input wire logic clk,
    input wire logic [opu_pkg::NUM_PAIR-1:0] shortReq,
    input wire logic [opu_pkg::NUM_TPIN-1:0] timerOff,
    input wire logic [opu_pkg::NUM_PPIN-1:0] pwmOff,
    output logic [opu_pkg::NUM_TPIN-1:0] timerPinLvl,
    output logic [opu_pkg::NUM_PPIN-1:0] pwmPinLvl
);
    logic [NUM_TPIN-1:0] tDrv;
    logic [NUM_PPIN-1:0] pDrv;
    logic [NUM_TPIN-1:0] tLast_r;
    logic [NUM_PPIN-1:0] pLast_r;
    // first pin of a pair high, second low; a request drives both high
    assign tDrv = 20'h034D0 | {4'h0, shortReq[5:4], 2'b00, shortReq[3], 1'b0, shortReq[2:1],
        2'b00, shortReq[0], 5'h00};
    assign pDrv = 8'h55 | {2'b00, shortReq[8], 1'b0, shortReq[7], 1'b0, shortReq[6], 1'b0};
    // released pins float: inverse of last driven level
    assign timerPinLvl = (tDrv & ~timerOff) | (~tLast_r & timerOff);
    assign pwmPinLvl = (pDrv & ~pwmOff) | (~pLast_r & pwmOff);
    always_ff @(posedge clk) begin
        tLast_r <= (tDrv & ~timerOff) | (tLast_r & timerOff);
        pLast_r <= (pDrv & ~pwmOff) | (pLast_r & pwmOff);
    end
endmodule // pin_model
`default_nettype wire

// File: tb/output_protect_unit_test.sv
// self-checking bench for the output protect unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module output_protect_unit_test;
    import opu_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, err;
    logic [NUM_FAULT-1:0] faultInN = '1;
    logic oscStop = 1'b0;
    logic cmpDetect = 1'b0;
    logic [NUM_PAIR-1:0] shortReq = '0;
    logic [NUM_TPIN-1:0] timerPinLvl, timerHiz, timerGpio;
    logic [NUM_PPIN-1:0] pwmPinLvl, pwmHiz, pwmGpio;
    logic [NUM_TPIN-1:0] tMask [5] = '{20'h003F0, 20'h0FC00, 20'h0000F, 20'hF0000, 20'h0};
    int div [4] = '{0, 8, 16, 128};
    int mismatches = 0;
    int n_tests = 0;
    always #20 clk = ~clk;
    output_protect_unit output_protect_unit_inst (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .faultInN(faultInN), .oscStop(oscStop),
        .cmpDetect(cmpDetect), .timerPinLvl(timerPinLvl), .pwmPinLvl(pwmPinLvl),
        .timerHiz(timerHiz), .timerGpio(timerGpio), .pwmHiz(pwmHiz), .pwmGpio(pwmGpio), .irq(irq));
    pin_model pin_model_inst (.clk(clk), .shortReq(shortReq), .timerOff(timerHiz | timerGpio),
        .pwmOff(pwmHiz | pwmGpio), .timerPinLvl(timerPinLvl), .pwmPinLvl(pwmPinLvl));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("read", e, rd)
    endtask
    task automatic clearAll(input logic [31:0] m);
        rdchk(OFS_STATUS, m);
        apb(1'b1, OFS_CLEAR, 32'h0001FFFF);
        repeat (2) @(posedge clk);
        `CHK("released", 20'h0, timerHiz)
        `CHK("irq low", 1'b0, irq)
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #1000000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdchk(OFS_ACTLVL, 32'h0003FFFF);
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, OFS_HIZEN, 32'h003FFFFF);
        apb(1'b1, OFS_INTEN, 32'h0001FFFF);
        for (int g = 0; g < NUM_GRP; g++) begin
            apb(1'b1, OFS_CTRL, 32'h1 << (CTRL_SW_LSB + g));
            rdchk(OFS_HALT, 32'h1 << g);
            `CHK("timer halt", tMask[g], timerHiz)
            `CHK("pwm halt", (g == GRP_PWM) ? 8'hFF : 8'h0, pwmHiz)
        end
        apb(1'b1, OFS_CTRL, 32'h00002900);
        repeat (2) @(posedge clk);
        `CHK("gpio", 20'h0000F, timerGpio)
        `CHK("pwm gpio", 8'hFF, pwmGpio)
        `CHK("pwm gpio not hiz", 8'h00, pwmHiz)
        apb(1'b1, OFS_CTRL, 32'h0);
        for (int k = 0; k < 2; k++) begin
            {cmpDetect, oscStop} <= 2'b01 << k;
            @(posedge clk);
            {cmpDetect, oscStop} <= 2'b00;
            repeat (3) @(posedge clk);
            `CHK("all halted", 20'hFFFFF, timerHiz)
            `CHK("irq", 1'b1, irq)
            clearAll(32'h1 << (ST_OSC + k));
        end
        apb(1'b1, OFS_CTRL, 32'h3E);
        for (int i = 0; i < NUM_FAULT; i++) begin
            faultInN[i] <= 1'b0;
            repeat (4) @(posedge clk);
            `CHK("fault halt", (i == 0) ? 20'h0 : 20'hFFFFF, timerHiz)
            faultInN[i] <= 1'b1;
            clearAll(32'h1 << i);
        end
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, OFS_INMODE, m);
            faultInN[0] <= 1'b0;
            repeat (15 * div[m] - 8) @(posedge clk);
            rdchk(OFS_STATUS, 32'h0);
            repeat (div[m] + 12) @(posedge clk);
            rdchk(OFS_STATUS, 32'h1);
            faultInN[0] <= 1'b1;
            clearAll(32'h1);
        end
        apb(1'b1, OFS_CTRL, 32'hC0);
        for (int k = 0; k < NUM_PAIR; k++) begin
            shortReq <= 9'h1 << k;
            @(posedge clk);
            shortReq <= '0;
            repeat (3) @(posedge clk);
            `CHK("short timer", (k < 6) ? 20'h0FFF0 : 20'h0, timerHiz)
            `CHK("short pwm", (k < 6) ? 8'h0 : 8'hFF, pwmHiz)
            clearAll(32'h40 << k);
        end
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_ACTLVL, 32'h0003FFFD);
        repeat (2) @(posedge clk);
        `CHK("short off", 20'h0, timerHiz)
        apb(1'b1, OFS_CLEAR, 32'h00000040);
        rdchk(OFS_STATUS, 32'h00000040);
        apb(1'b1, OFS_ACTLVL, 32'h0003FFFF);
        clearAll(32'h40);
        apb(1'b1, OFS_INTEN, 32'h0);
        oscStop <= 1'b1;
        @(posedge clk);
        oscStop <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("masked irq", 1'b0, irq)
        report_and_stop();
    end
endmodule // output_protect_unit_test
`default_nettype wire
